// ### src/timer_pkg.sv
package timer_pkg;

  // Register byte offsets on the four-bit word-aligned bus address.
  localparam int          ADDR_W        = 4;
  localparam logic [1:0]  IDX_EVEN_CTRL = 2'h0;
  localparam logic [1:0]  IDX_ODD_CTRL  = 2'h1;
  localparam logic [1:0]  IDX_STATUS    = 2'h2;
  localparam logic [3:0]  OFF_EVEN_CTRL = 4'h0;
  localparam logic [3:0]  OFF_ODD_CTRL  = 4'h4;
  localparam logic [3:0]  OFF_STATUS    = 4'h8;

  // Field positions inside timer_control.
  localparam int ON_BIT    = 15;
  localparam int IDLE_BIT  = 13;
  localparam int GATE_BIT  = 7;
  localparam int PS_HI     = 6;
  localparam int PS_LO     = 4;
  localparam int PAIR_BIT  = 3;
  localparam int CS_BIT    = 1;

  // Writable bits per timer; the odd timer has no pairing bit.
  localparam logic [31:0] EVEN_MASK  = 32'h0000_A0FA;
  localparam logic [31:0] ODD_MASK   = 32'h0000_A0F2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Status register fields.
  localparam int ST_EVEN_RUN = 0;
  localparam int ST_ODD_RUN  = 1;
  localparam int ST_PAIRED   = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } bus_state_t;

  // Terminal count of the prescaler for each ratio select code.
  function automatic logic [7:0] ratio_limit(input logic [2:0] sel);
    case (sel)
      3'h0:    ratio_limit = 8'h00;
      3'h1:    ratio_limit = 8'h01;
      3'h2:    ratio_limit = 8'h03;
      3'h3:    ratio_limit = 8'h07;
      3'h4:    ratio_limit = 8'h0F;
      3'h5:    ratio_limit = 8'h1F;
      3'h6:    ratio_limit = 8'h3F;
      default: ratio_limit = 8'hFF;
    endcase
  endfunction

  // Maps a byte address to a register index; 3 means unmapped.
  function automatic logic [1:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr[3:2];
  endfunction

endpackage

// ### src/prescale_if.sv
`timescale 1ns/1ns
interface prescale_if;
  logic       run;
  logic       source;
  logic [2:0] sel;
  logic       tick;
  modport ctrl (output run, output source, output sel, input tick);
  modport counter (input run, input source, input sel, output tick);
endinterface

// ### src/prescale_counter.sv
`timescale 1ns/1ns
module prescale_counter #(
  parameter int CNT_W = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  prescale_if.counter           port
);
  import timer_pkg::*;

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             tick_q;
  logic             next_tick;
  logic [CNT_W-1:0] limit;

  // The largest ratio needs eight bits of count.
  generate
    if (CNT_W < 8)
    begin : g_bad_width
      $error("prescale_counter needs CNT_W of at least 8");
    end
  endgenerate

  assign limit    = CNT_W'(ratio_limit(port.sel));
  assign port.tick = tick_q;

  // Count source pulses and emit one tick per full ratio; a stopped timer
  // restarts from zero so a ratio set while stopped never sees a stale partial count.
  always_comb
  begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (!port.run)
      next_cnt = '0;
    else if (port.source)
    begin
      if (cnt == limit)
      begin
        next_cnt  = '0;
        next_tick = 1'b1;
      end
      else
        next_cnt = cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt    <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt    <= next_cnt;
      tick_q <= next_tick;
    end
  end

  ratio_exact_a: assert property (@(posedge aclk) disable iff (!aresetn)
    port.tick |-> ($past(cnt) == CNT_W'(ratio_limit($past(port.sel))) && $past(port.run) && $past(port.source)))
    else $error("Tick without a full prescale count.");

endmodule // prescale_counter

// ### src/type_b_timer_control.sv
`timescale 1ns/1ns
// Behaviour
// - Enable bit fifteen runs the timer when set, stops it when clear; resets clear.
// - With idle-stop bit thirteen set, the timer halts during Idle mode.
// - With external clock selected, gating bit is ignored and reads back zero.
// - With internal clock, gating bit selects gated accumulation, clear gives timing.
// - Prescale bits six to four divide input by 1,2,4,8,16,32,64,256.
// - Only the even timer has the 32-bit pairing bit.
// - When paired, odd timer settings do nothing except its idle-stop bit, which also halts the pair in Idle; even timer controls both.
// - Bits 31-16, 14, 12-8, 2 and 0 read as zero.
module type_b_timer_control (
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire logic [timer_pkg::ADDR_W-1:0]    awaddr,
  input  wire logic                            awvalid,
  output logic                                 awready,
  input  wire logic [31:0]                     wdata,
  input  wire logic [3:0]                      wstrb,
  input  wire logic                            wvalid,
  output logic                                 wready,
  output logic [1:0]                           bresp,
  output logic                                 bvalid,
  input  wire logic                            bready,
  input  wire logic [timer_pkg::ADDR_W-1:0]    araddr,
  input  wire logic                            arvalid,
  output logic                                 arready,
  output logic [31:0]                          rdata,
  output logic [1:0]                           rresp,
  output logic                                 rvalid,
  input  wire logic                            rready,
  input  wire logic                            idle_mode,
  input  wire logic [1:0]                      ext_clock,
  input  wire logic [1:0]                      gate_in,
  output logic                                 advance_even,
  output logic                                 advance_odd,
  output logic                                 pair_wide_active
);
  import timer_pkg::*;

  logic [31:0]       ctrl [2];
  logic [31:0]       next_ctrl [2];
  bus_state_t        wstate, next_wstate, rstate, next_rstate;
  logic              aw_held, next_aw_held, w_held, next_w_held;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0]       w_data, next_w_data;
  logic [3:0]        w_strb, next_w_strb;
  logic              next_awready, next_wready, next_arready;
  logic              next_bvalid, next_rvalid;
  logic [1:0]        next_bresp, next_rresp;
  logic [31:0]       next_rdata, byte_mask;
  logic [1:0]        s1, s2, s3, ext_filt, ext_edge, g1, g2, g3, gate_filt;
  logic              paired, next_paired;
  logic [1:0]        run, src, gated;
  logic [2:0]        run_q;

  prescale_if pif [2] ();

  // Pins pass three flops; a level counts once the second and third agree.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {s1, s2, s3, ext_filt, ext_edge} <= '0;
      {g1, g2, g3, gate_filt}          <= '0;
    end
    else
    begin
      s1 <= ext_clock;
      s2 <= s1;
      s3 <= s2;
      g1 <= gate_in;
      g2 <= g1;
      g3 <= g2;
      for (int i = 0; i < 2; i++)
      begin
        if (s2[i] == s3[i])
          ext_filt[i] <= s3[i];
        ext_edge[i] <= (s2[i] == s3[i]) && s3[i] && !ext_filt[i];
        if (g2[i] == g3[i])
          gate_filt[i] <= g3[i];
      end
    end
  end

  // Effective settings; in paired mode the even timer owns every setting,
  // except that either idle-stop bit halts the pair in Idle mode.
  assign paired = ctrl[0][PAIR_BIT];
  assign run[0] = ctrl[0][ON_BIT]
                  && !(idle_mode && ctrl[0][IDLE_BIT])
                  && !(paired && idle_mode && ctrl[1][IDLE_BIT]);
  assign run[1] = !paired && ctrl[1][ON_BIT] && !(idle_mode && ctrl[1][IDLE_BIT]);

  generate
    for (genvar t = 0; t < 2; t++)
    begin : g_timer
      assign gated[t] = ctrl[t][GATE_BIT] && !ctrl[t][CS_BIT];
      // External edges or every bus clock, the latter masked by the gate.
      assign src[t] = ctrl[t][CS_BIT] ? ext_edge[t]
                    : (gated[t] ? gate_filt[t] : 1'b1);
      assign pif[t].run    = run[t];
      assign pif[t].source = src[t];
      assign pif[t].sel    = ctrl[t][PS_HI:PS_LO];
      prescale_counter #(.CNT_W(8)) u_count (
        .aclk    (aclk),
        .aresetn (aresetn),
        .port    (pif[t])
      );
    end
  endgenerate

  assign advance_even = pif[0].tick;
  assign advance_odd  = pif[1].tick;
  assign byte_mask    = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  // Write channel: address and data are caught in either order, then the
  // register updates and the response is raised in the same edge.
  always_comb
  begin
    next_ctrl    = ctrl;
    next_wstate  = wstate;
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    case (wstate)
      BUS_IDLE:
      begin
        if (awvalid && awready)
        begin
          next_aw_held = 1'b1;
          next_aw_addr = awaddr;
        end
        if (wvalid && wready)
        begin
          next_w_held = 1'b1;
          next_w_data = wdata;
          next_w_strb = wstrb;
        end
        if (aw_held && w_held)
        begin
          next_aw_held = 1'b0;
          next_w_held  = 1'b0;
          next_bvalid  = 1'b1;
          next_wstate  = BUS_RESP;
          next_bresp   = RESP_OKAY;
          case (reg_index(aw_addr))
            IDX_EVEN_CTRL: next_ctrl[0] = (ctrl[0] & ~(byte_mask & EVEN_MASK))
                                          | (w_data & byte_mask & EVEN_MASK);
            IDX_ODD_CTRL:  next_ctrl[1] = (ctrl[1] & ~(byte_mask & ODD_MASK))
                                          | (w_data & byte_mask & ODD_MASK);
            IDX_STATUS:    next_bresp   = RESP_OKAY;
            default:       next_bresp   = RESP_SLVERR;
          endcase
        end
      end
      BUS_RESP:
      begin
        if (bready)
        begin
          next_bvalid = 1'b0;
          next_wstate = BUS_IDLE;
        end
      end
      default: next_wstate = BUS_IDLE;
    endcase
    next_awready = (next_wstate == BUS_IDLE) && !next_aw_held;
    next_wready  = (next_wstate == BUS_IDLE) && !next_w_held;
  end

  // Read channel: one read at a time, data sampled when the address is taken.
  always_comb
  begin
    next_rstate = rstate;
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    case (rstate)
      BUS_IDLE:
      begin
        if (arvalid && arready)
        begin
          next_rvalid = 1'b1;
          next_rstate = BUS_RESP;
          next_rresp  = RESP_OKAY;
          next_rdata  = '0;
          case (reg_index(araddr))
            IDX_EVEN_CTRL: next_rdata = ctrl[0] & ~(32'(ctrl[0][CS_BIT]) << GATE_BIT);
            IDX_ODD_CTRL:  next_rdata = ctrl[1] & ~(32'(ctrl[1][CS_BIT]) << GATE_BIT);
            IDX_STATUS:    next_rdata = 32'(run_q);
            default:       next_rresp = RESP_SLVERR;
          endcase
        end
      end
      BUS_RESP:
      begin
        if (rready)
        begin
          next_rvalid = 1'b0;
          next_rstate = BUS_IDLE;
        end
      end
      default: next_rstate = BUS_IDLE;
    endcase
    next_arready = (next_rstate == BUS_IDLE);
    next_paired  = paired;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl[0]          <= CTRL_RESET;
      ctrl[1]          <= CTRL_RESET;
      wstate           <= BUS_IDLE;
      rstate           <= BUS_IDLE;
      {aw_held, w_held} <= 2'b00;
      aw_addr          <= '0;
      w_data           <= '0;
      w_strb           <= '0;
      {awready, wready, arready, bvalid, rvalid} <= '0;
      bresp            <= RESP_OKAY;
      rresp            <= RESP_OKAY;
      rdata            <= '0;
      pair_wide_active <= 1'b0;
      run_q            <= '0;
    end
    else
    begin
      ctrl             <= next_ctrl;
      wstate           <= next_wstate;
      rstate           <= next_rstate;
      aw_held          <= next_aw_held;
      w_held           <= next_w_held;
      aw_addr          <= next_aw_addr;
      w_data           <= next_w_data;
      w_strb           <= next_w_strb;
      awready          <= next_awready;
      wready           <= next_wready;
      arready          <= next_arready;
      bvalid           <= next_bvalid;
      rvalid           <= next_rvalid;
      bresp            <= next_bresp;
      rresp            <= next_rresp;
      rdata            <= next_rdata;
      pair_wide_active <= next_paired;
      run_q            <= {paired, run};
    end
  end

  disabled_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl[0][ON_BIT] |=> !advance_even)
    else $error("Even timer advanced while disabled.");

  idle_halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (idle_mode && ctrl[1][IDLE_BIT] && !paired) |=> !advance_odd)
    else $error("Odd timer advanced in Idle with idle-stop set.");

  gate_reads_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && arready && reg_index(araddr) == IDX_EVEN_CTRL && ctrl[0][CS_BIT]) |=> !rdata[GATE_BIT])
    else $error("Gating bit read as one with external clock.");

  gate_closed_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl[0][GATE_BIT] && !ctrl[0][CS_BIT] && !gate_filt[0]) |=> !advance_even)
    else $error("Gated timer advanced with gate low.");

  odd_no_pair_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(bvalid) |-> !ctrl[1][PAIR_BIT])
    else $error("Odd timer holds a pairing bit.");

  paired_odd_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    paired [*2] |-> !advance_odd)
    else $error("Odd timer advanced while paired.");

  reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && arready && reg_index(araddr) != IDX_STATUS)
      |=> (rdata[31:16] == 16'h0000 && !rdata[14] && rdata[12:8] == 5'h00 && !rdata[2] && !rdata[0]))
    else $error("Unimplemented bits read as nonzero.");

  ext_source_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl[0][CS_BIT] && !ext_edge[0]) |=> !advance_even)
    else $error("External-clock timer advanced without an edge.");

  bus_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && arready) |=> rvalid)
    else $error("Read not answered in one cycle.");

endmodule // type_b_timer_control

// ### testbench/test_type_b_timer_control.sv
`timescale 1ns/1ns
module test_type_b_timer_control;
  import timer_pkg::*;
  logic        aclk;
  logic        aresetn;
  logic [3:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [3:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        idle_mode;
  logic [1:0]  ext_clock;
  logic [1:0]  gate_in;
  logic        advance_even;
  logic        advance_odd;
  logic        pair_wide_active;
  int          err_count;
  int          total_checks;
  int          even_pulses;
  int          odd_pulses;
  logic [1:0]  resp;
  logic [31:0] data;
  int          e;
  int          o;

  type_b_timer_control dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .idle_mode(idle_mode),
    .ext_clock(ext_clock), .gate_in(gate_in), .advance_even(advance_even), .advance_odd(advance_odd),
    .pair_wide_active(pair_wide_active));

  // The clock toggles every 20 ns, a half period of the 40 ns period.
  initial aclk = 1'b0;
  always #20 aclk = ~aclk;

  // Running tallies of advance pulses; windows are measured as differences.
  always @(posedge aclk)
  begin
    if (advance_even === 1'b1) even_pulses <= even_pulses + 1;
    if (advance_odd === 1'b1) odd_pulses <= odd_pulses + 1;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (exp !== got)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // A bus that never answers counts as a mismatch and ends the run.
  task automatic hang(input string name);
    err_count++;
    $display("[FAIL] %s expected answer seen none", name);
    complete_run();
  endtask

  // Address and data are offered together; bready stays up until the response is seen.
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
    end
    hang("write response");
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
    end
    hang("read data");
  endtask

  // Writes a control word, lets synchronisers settle, then counts pulses over n edges.
  task automatic run_window(input logic [3:0] a, input logic [31:0] d, input int n);
    int e0;
    int o0;
    axi_write(a, d, resp);
    repeat (20) @(posedge aclk);
    e0 = even_pulses;
    o0 = odd_pulses;
    repeat (n) @(posedge aclk);
    e = even_pulses - e0;
    o = odd_pulses - o0;
  endtask

  task automatic test_registers();
    axi_read(OFF_EVEN_CTRL, data, resp);
    check("even reset", CTRL_RESET, data);
    axi_write(OFF_EVEN_CTRL, 32'hFFFF_FFFF, resp);
    check("write okay", RESP_OKAY, resp);
    axi_read(OFF_EVEN_CTRL, data, resp);
    check("even ones", 32'h0000_A07A, data);
    check("read okay", RESP_OKAY, resp);
    axi_write(OFF_ODD_CTRL, 32'hFFFF_FFFF, resp);
    axi_read(OFF_ODD_CTRL, data, resp);
    check("odd ones", 32'h0000_A072, data);
    axi_write(OFF_EVEN_CTRL, 32'h0000_0080, resp);
    axi_read(OFF_EVEN_CTRL, data, resp);
    check("gate internal", 32'h0000_0080, data);
    axi_write(4'hC, 32'h0000_8000, resp);
    check("unmapped write", RESP_SLVERR, resp);
    axi_read(4'hC, data, resp);
    check("unmapped read", RESP_SLVERR, resp);
    axi_write(OFF_ODD_CTRL, 32'h0000_0000, resp);
    $display("test registers done");
  endtask

  task automatic test_prescale();
    int s;
    int r;
    // Any window of four periods holds exactly four pulses.
    for (s = 0; s < 8; s++)
    begin
      r = (s == 7) ? 256 : (1 << s);
      run_window(OFF_EVEN_CTRL, 32'h0000_8000 | (s << 4), 4 * r);
      check("prescale pulses", 4, e);
    end
    run_window(OFF_EVEN_CTRL, 32'h0000_0000, 300);
    check("disabled pulses", 0, e);
    $display("test prescale done");
  endtask

  task automatic test_idle();
    idle_mode <= 1'b1;
    axi_write(OFF_ODD_CTRL, 32'h0000_A000, resp);
    run_window(OFF_EVEN_CTRL, 32'h0000_A000, 100);
    check("idle stop", 0, e);
    check("odd idle stop", 0, o);
    run_window(OFF_EVEN_CTRL, 32'h0000_8000, 100);
    check("idle run", 100, e);
    idle_mode <= 1'b0;
    $display("test idle done");
  endtask

  task automatic test_gate();
    int e0;
    run_window(OFF_EVEN_CTRL, 32'h0000_8080, 50);
    check("gate low", 0, e);
    e0 = even_pulses;
    gate_in <= 2'b01;
    repeat (20) @(posedge aclk);
    gate_in <= 2'b00;
    repeat (10) @(posedge aclk);
    check("gate high", 20, even_pulses - e0);
    run_window(OFF_EVEN_CTRL, 32'h0000_8000, 50);
    check("timing mode", 50, e);
    // Gate bit set with external source: ignored, reads zero, edges counted at 1:2.
    run_window(OFF_EVEN_CTRL, 32'h0000_8092, 0);
    axi_read(OFF_EVEN_CTRL, data, resp);
    check("gate read ext", 32'h0000_8012, data);
    e0 = even_pulses;
    repeat (8)
    begin
      ext_clock <= 2'b01;
      repeat (3) @(posedge aclk);
      ext_clock <= 2'b00;
      repeat (3) @(posedge aclk);
    end
    repeat (10) @(posedge aclk);
    check("ext edges", 4, even_pulses - e0);
    $display("test gate done");
  endtask

  task automatic test_pair();
    axi_write(OFF_ODD_CTRL, 32'h0000_8030, resp);
    run_window(OFF_EVEN_CTRL, 32'h0000_8008, 64);
    check("pair even", 64, e);
    check("pair odd", 0, o);
    check("pair flag", 1, pair_wide_active);
    axi_read(OFF_STATUS, data, resp);
    check("status paired", 32'h0000_0005, data);
    // Both idle-stop bits clear keep the pair counting in Idle.
    idle_mode <= 1'b1;
    run_window(OFF_EVEN_CTRL, 32'h0000_8008, 32);
    check("pair idle run", 32, e);
    run_window(OFF_ODD_CTRL, 32'h0000_A030, 32);
    check("pair odd idle stop", 0, e);
    idle_mode <= 1'b0;
    run_window(OFF_ODD_CTRL, 32'h0000_8000, 0);
    run_window(OFF_EVEN_CTRL, 32'h0000_0000, 64);
    check("single odd", 64, o);
    check("single even", 0, e);
    $display("test pair done");
  endtask

  initial
  begin
    aresetn = 1'b0;
    awaddr = 4'h0;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 4'h0;
    arvalid = 1'b0;
    rready = 1'b0;
    idle_mode = 1'b0;
    ext_clock = 2'b00;
    gate_in = 2'b00;
    err_count = 0;
    total_checks = 0;
    even_pulses = 0;
    odd_pulses = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    test_registers();
    test_prescale();
    test_idle();
    test_gate();
    test_pair();
    complete_run();
  end
endmodule // test_type_b_timer_control
